// *** hdl/kwi_pkg.sv ***
// package: register map, field positions and reset values of the keypad wake-up block
// assumes: included before the design module, nothing imported
package kwi_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PIN_ENABLE = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  // ****************************************************************
  // fields of keypad_status_control
  // ****************************************************************
  localparam int POS_MODE = 0;
  localparam int POS_IRQ_ENABLE = 1;
  localparam int POS_ACK = 2;
  localparam int POS_FLAG = 3;
  localparam int POS_POLARITY = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [3:0] RST_POLARITY = 4'h0;
  localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
  localparam logic [0:0] RST_IRQ_MASK = 1'h0;

  // bus answer state
  typedef enum logic [0:0] {
    KWI_IDLE = 1'b0,
    KWI_DONE = 1'b1
  } kwi_bus_t;

endpackage

// *** hdl/kwi_top.sv ***
// keypad wake-up interrupt: eight port pins, edge or edge-and-level sense
// assumes: pins asynchronous to clock; Avalon-MM master with waitrequest
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - upper four pins have selectable polarity
// - one means rising/high, zero falling/low
// - lower four pins fixed falling/low sense
// - only enabled pins can set flag
// - detected trigger event sets event flag
// - event flag ignores the written flag bit
// - acknowledge write clears flag
// - in level mode a held asserted level keeps flag set
// - acknowledge bit always reads zero
// - irq enable gates flag onto request
// - mode bit selects edge or edge-and-level
module kwi_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // keypad pins
  input wire logic [7:0] keypad_pin,
  // interrupt outputs
  output logic keypad_irq,
  output logic irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] stable;
    logic [3:0] edge_polarity_select;
    logic level_sense_mode;
    logic event_irq_enable;
    logic keypad_event_flag;
    logic [7:0] pin_keypad_enable;
    logic irq_status;
    logic irq_mask;
    kwi_pkg::kwi_bus_t bus;
    logic [31:0] readdata;
    logic keypad_irq;
    logic irq;
    logic waitrequest;
  } kwi_state_t;

  kwi_state_t state;
  kwi_state_t next_state;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // per-pin active sense: upper pins follow polarity, lower fixed low
  function automatic logic [7:0] kwi_asserted(input logic [7:0] lvl, input logic [3:0] pol);
    logic [7:0] sense;
    sense = {pol, 4'h0};
    return ~(lvl ^ sense);
  endfunction

  // full compare: holes between offsets select nothing
  function automatic logic kwi_hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction

  // status/control image; the ack position is never stored
  function automatic logic [7:0] kwi_control_image(
    input logic [3:0] pol,
    input logic flag,
    input logic irq_en,
    input logic mode
  );
    logic [7:0] image;
    image = 8'h00;
    image[kwi_pkg::POS_POLARITY +: 4] = pol;
    image[kwi_pkg::POS_FLAG] = flag;
    image[kwi_pkg::POS_ACK] = 1'b0;
    image[kwi_pkg::POS_IRQ_ENABLE] = irq_en;
    image[kwi_pkg::POS_MODE] = mode;
    return image;
  endfunction

  // any pin of a vector
  function automatic logic kwi_any(input logic [7:0] vec);
    return vec != 8'h00;
  endfunction

  // ****************************************************************
  // pin filter and event detection
  // ****************************************************************
  logic [7:0] stable_now;
  logic [7:0] stable_prev;
  logic [7:0] asserted_now;
  logic [7:0] asserted_prev;

  logic [7:0] edge_hit;
  logic [7:0] level_hit;
  logic edge_any;
  logic level_hold;
  logic trigger;

  always_comb begin
    stable_now = state.stable;
    stable_prev = state.stable;
    edge_hit = 8'h00;
    level_hit = 8'h00;
    // a change counts once second and third stage agree
    for (int pin = 0; pin < 8; pin++) begin
      if (state.sync2[pin] == state.sync3[pin]) begin
        stable_now[pin] = state.sync3[pin];
      end
    end
    asserted_now = kwi_asserted(stable_now, state.edge_polarity_select);
    asserted_prev = kwi_asserted(stable_prev, state.edge_polarity_select);
    // disabled pins never reach the flag
    for (int pin = 0; pin < 8; pin++) begin
      if (state.pin_keypad_enable[pin]) begin
        edge_hit[pin] = asserted_now[pin] && !asserted_prev[pin];
        level_hit[pin] = asserted_now[pin];
      end
    end
    edge_any = kwi_any(edge_hit);
    level_hold = state.level_sense_mode && kwi_any(level_hit);
    trigger = edge_any || level_hold;
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic bus_req;
  logic sel_control;
  logic sel_enable;
  logic sel_status;
  logic sel_mask;

  logic wr_control;
  logic wr_enable;
  logic wr_mask;
  logic ack_write;

  logic rd_control;
  logic rd_enable;
  logic rd_status;
  logic rd_mask;

  always_comb begin
    // a request is taken once, in its first cycle
    bus_req = (read || write) && state.bus == kwi_pkg::KWI_IDLE;
    sel_control = 1'b0;
    sel_enable = 1'b0;
    sel_status = 1'b0;
    sel_mask = 1'b0;
    if (kwi_hit(address, kwi_pkg::OFS_STATUS_CONTROL)) begin
      sel_control = 1'b1;
    end else if (kwi_hit(address, kwi_pkg::OFS_PIN_ENABLE)) begin
      sel_enable = 1'b1;
    end else if (kwi_hit(address, kwi_pkg::OFS_IRQ_STATUS)) begin
      sel_status = 1'b1;
    end else if (kwi_hit(address, kwi_pkg::OFS_IRQ_MASK)) begin
      sel_mask = 1'b1;
    end
    wr_control = bus_req && write && sel_control;
    wr_enable = bus_req && write && sel_enable;
    wr_mask = bus_req && write && sel_mask;
    ack_write = wr_control && writedata[kwi_pkg::POS_ACK];
    rd_control = bus_req && read && sel_control;
    rd_enable = bus_req && read && sel_enable;
    rd_status = bus_req && read && sel_status;
    rd_mask = bus_req && read && sel_mask;
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  kwi_pkg::kwi_bus_t bus_next;
  logic waitrequest_next;

  always_comb begin
    bus_next = state.bus;
    // one wait cycle, answer on the second
    case (state.bus)
      kwi_pkg::KWI_IDLE: begin
        if (read || write) begin
          bus_next = kwi_pkg::KWI_DONE;
        end
      end
      kwi_pkg::KWI_DONE: begin
        bus_next = kwi_pkg::KWI_IDLE;
      end
      default: begin
        bus_next = kwi_pkg::KWI_IDLE;
      end
    endcase
    // registered: waitrequest stands high while no answer is due
    waitrequest_next = bus_next != kwi_pkg::KWI_DONE;
  end

  // ****************************************************************
  // write capture
  // ****************************************************************
  logic [3:0] wr_polarity;
  logic wr_irq_enable;
  logic wr_mode;
  logic [7:0] wr_pins;
  logic wr_mask_bit;

  always_comb begin
    // the flag position of writedata reaches state only as the pin 3 enable bit
    wr_polarity = writedata[kwi_pkg::POS_POLARITY +: 4];
    wr_irq_enable = writedata[kwi_pkg::POS_IRQ_ENABLE];
    wr_mode = writedata[kwi_pkg::POS_MODE];
    wr_pins = writedata[7:0];
    wr_mask_bit = writedata[0];
  end

  // ****************************************************************
  // read back
  // ****************************************************************
  logic [7:0] rd_image;

  always_comb begin
    rd_image = 8'h00;
    if (rd_control) begin
      rd_image = kwi_control_image(state.edge_polarity_select, state.keypad_event_flag,
        state.event_irq_enable, state.level_sense_mode);
    end else if (rd_enable) begin
      rd_image = state.pin_keypad_enable;
    end else if (rd_status) begin
      rd_image[0] = state.irq_status;
    end else if (rd_mask) begin
      rd_image[0] = state.irq_mask;
    end
  end

  // ****************************************************************
  // flag and status set/clear
  // ****************************************************************
  logic flag_set;
  logic flag_clear;
  logic status_set;
  logic status_clear;

  always_comb begin
    // hardware set wins when an acknowledge lands in the same cycle
    // level mode re-sets the flag every cycle a pin holds its level
    flag_set = trigger;
    flag_clear = ack_write && !trigger;
    // status records only the first event of a burst
    status_set = trigger && !state.keypad_event_flag;
    status_clear = rd_status && !status_set;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;

    // only stage two reads stage one
    next_state.sync1 = keypad_pin;
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    next_state.stable = stable_now;

    if (flag_set) begin
      next_state.keypad_event_flag = 1'b1;
    end else if (flag_clear) begin
      next_state.keypad_event_flag = 1'b0;
    end

    next_state.bus = bus_next;
    next_state.waitrequest = waitrequest_next;

    // control write: flag position dropped, ack is only a strobe
    if (wr_control) begin
      next_state.edge_polarity_select = wr_polarity;
      next_state.event_irq_enable = wr_irq_enable;
      next_state.level_sense_mode = wr_mode;
    end
    if (wr_enable) begin
      next_state.pin_keypad_enable = wr_pins;
    end
    if (wr_mask) begin
      next_state.irq_mask = wr_mask_bit;
    end

    // read data stands for the answer cycle only
    next_state.readdata = {24'h00_0000, rd_image};

    if (status_set) begin
      next_state.irq_status = 1'b1;
    end else if (status_clear) begin
      next_state.irq_status = 1'b0;
    end

    // both requests leave flip-flops
    next_state.keypad_irq = next_state.keypad_event_flag && next_state.event_irq_enable;
    next_state.irq = next_state.irq_status && next_state.irq_mask;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state.sync1 <= 8'h00;
      state.sync2 <= 8'h00;
      state.sync3 <= 8'h00;
      state.stable <= 8'h00;
      state.edge_polarity_select <= kwi_pkg::RST_POLARITY;
      state.level_sense_mode <= 1'b0;
      state.event_irq_enable <= 1'b0;
      state.keypad_event_flag <= 1'b0;
      state.pin_keypad_enable <= kwi_pkg::RST_PIN_ENABLE;
      state.irq_status <= 1'b0;
      state.irq_mask <= kwi_pkg::RST_IRQ_MASK[0];
      state.bus <= kwi_pkg::KWI_IDLE;
      state.readdata <= 32'h0000_0000;
      state.keypad_irq <= 1'b0;
      state.irq <= 1'b0;
      state.waitrequest <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign readdata = state.readdata;
  assign waitrequest = state.waitrequest;
  assign keypad_irq = state.keypad_irq;
  assign irq = state.irq;

endmodule

`default_nettype wire

// *** dv/kwi_sva.sv ***
// checker: bus answer timing and irq fall causes at the ports of kwi_top
// assumes: one clock domain, bound to every kwi_top instance
`timescale 1ns/1ps
`default_nettype none
module kwi_sva (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // avalon-mm and interrupts
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic keypad_irq,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after wait");
  property p_first; $rose(read) |-> waitrequest; endproperty
  a_first: assert property (p_first) else $error("read answered at once");
  property p_ack; read && !waitrequest && address == 4'h0 |-> !readdata[2]; endproperty
  a_ack: assert property (p_ack) else $error("ack bit read back set");
  property p_wide; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
  a_wide: assert property (p_wide) else $error("upper read bits set");
  property p_hole; read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_idle; !(read && !waitrequest) |-> readdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  // flag drops only through a software write
  property p_kfall; $fell(keypad_irq) |-> $past(write) || $past(write, 2); endproperty
  a_kfall: assert property (p_kfall) else $error("request fell without write");
  property p_ifall; $fell(irq) |-> $past(read) || $past(write); endproperty
  a_ifall: assert property (p_ifall) else $error("irq fell without access");
endmodule
bind kwi_top kwi_sva kwi_sva_inst (.clock, .reset_n, .address, .read, .write, .readdata,
  .waitrequest, .keypad_irq, .irq);
`default_nettype wire

// *** dv/kwi_keys.sv ***
// key model: a pressed key pulls its pin low, pull-ups hold the rest high
// assumes: press driven by the bench at the clock edge
`timescale 1ns/1ps
`default_nettype none
module kwi_keys (
  // key state
  input wire logic [7:0] press,
  // port pins
  output logic [7:0] keypad_pin
);
  assign keypad_pin = ~press;
endmodule
`default_nettype wire

// *** dv/kwi_top_tb.sv ***
// bench: register accesses and key presses against kwi_top
// assumes: kwi_keys drives the pins, kwi_sva bound
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t bad value", $time); end end
module kwi_top_tb;
  logic clock = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, waitrequest, keypad_irq, irq;
  logic [3:0] address = 4'h0;
  logic [7:0] press = 8'h00, keypad_pin;
  logic [31:0] writedata = 32'h0, readdata, q;
  int errors = 0, checked = 0, cyc = 0;
  always #12.5 clock = ~clock;
  kwi_keys kwi_keys_inst (.press, .keypad_pin);
  kwi_top kwi_top_inst (.clock, .reset_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .keypad_pin, .keypad_irq, .irq);
  task automatic print_verdict;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // request held until the edge that samples waitrequest low; data taken there
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask
  // ten clocks cover synchroniser, flag and request latency
  task automatic key(input logic [7:0] p);
    press <= p;
    repeat (10) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      print_verdict;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'hC, 8'h00);
    rd(4'h1, 8'h00);
    acc(1'b1, 4'hC, 8'h01);
    acc(1'b1, 4'h4, 8'h11);
    acc(1'b1, 4'h0, 8'h02);
    key(8'h01);
    `CHK({keypad_irq, irq}, 2'b11)
    rd(4'h0, 8'h0A);
    rd(4'h8, 8'h01);
    acc(1'b1, 4'h0, 8'h0E);
    rd(4'h0, 8'h02);
    key(8'h00);
    `CHK({keypad_irq, irq}, 2'b00)
    acc(1'b1, 4'h0, 8'h0A);
    rd(4'h0, 8'h02);
    key(8'h02);
    rd(4'h0, 8'h02);
    acc(1'b1, 4'h0, 8'h12);
    key(8'h10);
    rd(4'h0, 8'h12);
    key(8'h00);
    rd(4'h0, 8'h1A);
    acc(1'b1, 4'h0, 8'h17);
    rd(4'h0, 8'h1B);
    acc(1'b1, 4'h0, 8'h16);
    rd(4'h0, 8'h1A);
    acc(1'b1, 4'h0, 8'h16);
    rd(4'h0, 8'h12);
    acc(1'b1, 4'hC, 8'h00);
    acc(1'b1, 4'h0, 8'h00);
    key(8'h01);
    rd(4'h0, 8'h08);
    `CHK({keypad_irq, irq}, 2'b00)
    print_verdict;
  end
endmodule
`default_nettype wire
